// ### logic/scan_port_pkg.sv
// Package with constants, types and states of the boundary-scan test port.
package scan_port_pkg;
   localparam int unsigned IR_W          = 4;
   localparam int unsigned PIN_N         = 8;
   localparam int unsigned MC_N          = 4;
   localparam int unsigned PIN_CELL_W    = 3;
   localparam int unsigned MC_CELL_W     = 2;
   localparam int unsigned CHAIN_W       = PIN_N * PIN_CELL_W + MC_N * MC_CELL_W;
   localparam int unsigned ID_W          = 32;
   localparam int unsigned PROG_W        = 16;
   localparam int unsigned FIFO_DEPTH    = 16;
   localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
   localparam logic [IR_W-1:0] IR_IDCODE  = 4'h2;
   localparam logic [IR_W-1:0] IR_PROGRAM = 4'h8;
   localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   // Identity value is arbitrary.
   localparam logic [ID_W-1:0] ID_VALUE   = 32'h0000_1001;

   typedef enum logic [15:0] {
      ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002, ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008, ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
      ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080, ST_UP_DR  = 16'h0100,
      ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000, ST_EX2_IR = 16'h4000,
      ST_UP_IR  = 16'h8000
   } tap_state_e;

   typedef struct packed {
      logic [PIN_N-1:0] data;
      logic [PIN_N-1:0] oe;
      logic [MC_N-1:0]  mc;
   } pin_drive_s;
endpackage

// ### logic/scan_word_fifo.sv
// Word FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module scan_word_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   wire logic        push = i_in_valid && o_in_ready;
   wire logic        pop  = o_out_valid && i_out_ready;

   assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem[rd_r];

   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop)  rd_r <= rd_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // scan_word_fifo

// ### logic/scan_test_port.sv
// Boundary-scan TAP, scan chain and programming path of the test port.
`timescale 1ns/1ns
module scan_test_port
   import scan_port_pkg::*;
(
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_reset,
   input  wire logic                 i_tck,
   input  wire logic                 i_port_enable,
   input  wire logic                 i_pullup_enable,
   input  wire logic                 i_tms,
   input  wire logic                 i_tdi,
   output logic                      o_tdo,
   output logic                      o_tdo_oe_n,
   output logic                      o_tms_pullup,
   output logic                      o_tdi_pullup,
   input  wire logic [3:0]           i_user_pin_out,
   input  wire logic [3:0]           i_user_pin_oe_n,
   output logic [3:0]                o_test_pin_out,
   output logic [3:0]                o_test_pin_oe_n,
   output logic [3:0]                o_test_pin_user_in,
   input  wire logic [PIN_N-1:0]     i_pin_in,
   input  wire logic [PIN_N-1:0]     i_core_out,
   input  wire logic [PIN_N-1:0]     i_core_oe,
   input  wire logic [MC_N-1:0]      i_mc_state,
   output pin_drive_s                o_pin_drive,
   output logic                      o_extest,
   output logic                      o_prog_valid,
   input  wire logic                 i_prog_ready,
   output logic [PROG_W-1:0]         o_prog_data,
   output logic                      o_prog_overflow
);
   // Link domain: TAP state machine and chain, clocked by TCK.
   tap_state_e            st_r;
   tap_state_e            st_nxt;
   logic [IR_W-1:0]       ir_sh_r;
   logic [IR_W-1:0]       ir_r;
   logic [CHAIN_W-1:0]    chain_r;
   logic [CHAIN_W-1:0]    upd_r;
   logic                  upd_tgl_r;
   logic [ID_W-1:0]       id_r;
   logic                  byp_r;
   logic [PROG_W-1:0]     prog_sh_r;
   logic [PROG_W-1:0]     prog_hold_r;
   logic                  prog_tgl_r;
   logic                  tdo_r;
   logic                  tdo_en_r;
   logic                  tms;
   logic                  tdi;

   // Port option gates the TAP; with it off the pins are ordinary I/O.
   assign tms = i_port_enable ? i_tms : 1'b1;
   assign tdi = i_tdi;
   assign o_tms_pullup = i_port_enable && i_pullup_enable;
   assign o_tdi_pullup = i_port_enable && i_pullup_enable;

   always_comb begin
      unique case (st_r)
         ST_RESET:  st_nxt = tms ? ST_RESET  : ST_IDLE;
         ST_IDLE:   st_nxt = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: st_nxt = tms ? ST_UP_DR  : ST_PA_DR;
         ST_PA_DR:  st_nxt = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: st_nxt = tms ? ST_UP_DR  : ST_SH_DR;
         ST_UP_DR:  st_nxt = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: st_nxt = tms ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: st_nxt = tms ? ST_UP_IR  : ST_PA_IR;
         ST_PA_IR:  st_nxt = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: st_nxt = tms ? ST_UP_IR  : ST_SH_IR;
         ST_UP_IR:  st_nxt = tms ? ST_SEL_DR : ST_IDLE;
         default:   st_nxt = ST_RESET;
      endcase
   end

   // Strobes for all data-register cells are derived here, never from pins directly.
   wire logic cap_dr = (st_r == ST_CAP_DR);
   wire logic sh_dr  = (st_r == ST_SH_DR);
   wire logic up_dr  = (st_r == ST_UP_DR);
   wire logic sel_extest  = (ir_r == IR_EXTEST);
   wire logic sel_sample  = (ir_r == IR_SAMPLE);
   wire logic sel_idcode  = (ir_r == IR_IDCODE);
   wire logic sel_program = (ir_r == IR_PROGRAM);
   wire logic sel_chain   = sel_extest || sel_sample;
   // Any unassigned code falls back to the bypass bit.
   wire logic sel_bypass  = !(sel_chain || sel_idcode || sel_program);

   // Live capture image: three stages per pin cell, two per macrocell cell.
   logic [CHAIN_W-1:0] cap_img;
   always_comb begin
      cap_img = '0;
      for (int i = 0; i < PIN_N; i++) begin
         cap_img[i*PIN_CELL_W +: PIN_CELL_W] = {i_core_oe[i], i_core_out[i], i_pin_in[i]};
      end
      for (int m = 0; m < MC_N; m++) begin
         cap_img[PIN_N*PIN_CELL_W + m*MC_CELL_W +: MC_CELL_W] = {1'b0, i_mc_state[m]};
      end
   end

   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         ir_sh_r <= '0;
         ir_r    <= IR_IDCODE;
      end else if (st_r == ST_RESET) begin
         ir_r <= IR_IDCODE;
      end else if (st_r == ST_CAP_IR) begin
         ir_sh_r <= IR_CAPTURE;
      end else if (st_r == ST_SH_IR) begin
         ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
      end else if (st_r == ST_UP_IR) begin
         ir_r <= ir_sh_r;
      end
   end

   // Core values are retimed twice on TCK before capture. TCK only runs during frames,
   // so a capture shows the core as it was two TCK edges earlier.
   logic [CHAIN_W-1:0] live_s1_r;
   logic [CHAIN_W-1:0] live_s2_r;
   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         live_s1_r <= '0;
         live_s2_r <= '0;
      end else begin
         live_s1_r <= cap_img;
         live_s2_r <= live_s1_r;
      end
   end

   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         chain_r <= '0;
      end else if (sel_chain && cap_dr) begin
         chain_r <= live_s2_r;
      end else if (sel_chain && sh_dr) begin
         chain_r <= {tdi, chain_r[CHAIN_W-1:1]};
      end
   end

   // Update stages load only on Update-DR so outputs stay steady while shifting.
   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         upd_r     <= '0;
         upd_tgl_r <= 1'b0;
      end else if (sel_chain && up_dr) begin
         upd_r     <= chain_r;
         upd_tgl_r <= !upd_tgl_r;
      end
   end

   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         id_r  <= '0;
         byp_r <= 1'b0;
      end else begin
         if (sel_idcode && cap_dr) id_r <= ID_VALUE;
         else if (sel_idcode && sh_dr) id_r <= {tdi, id_r[ID_W-1:1]};
         if (sel_bypass && cap_dr) byp_r <= 1'b0;
         else if (sel_bypass && sh_dr) byp_r <= tdi;
      end
   end

   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         prog_sh_r   <= '0;
         prog_hold_r <= '0;
         prog_tgl_r  <= 1'b0;
      end else if (sel_program && sh_dr) begin
         prog_sh_r <= {tdi, prog_sh_r[PROG_W-1:1]};
      end else if (sel_program && up_dr) begin
         prog_hold_r <= prog_sh_r;
         prog_tgl_r  <= !prog_tgl_r;
      end
   end

   // Serial output is chosen by state and instruction, then retimed on the falling edge.
   wire logic tdo_src = (st_r == ST_SH_IR) ? ir_sh_r[0]   :
                        sel_chain          ? chain_r[0]   :
                        sel_idcode         ? id_r[0]      :
                        sel_program        ? prog_sh_r[0] : byp_r;
   always_ff @(negedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         tdo_r    <= 1'b0;
         tdo_en_r <= 1'b0;
      end else begin
         tdo_r    <= tdo_src;
         tdo_en_r <= (st_r == ST_SH_IR) || sh_dr;
      end
   end
   assign o_tdo      = tdo_r;
   assign o_tdo_oe_n = !(i_port_enable && tdo_en_r);

   // Pin mux: test pins carry user I/O when the port option is off.
   assign o_test_pin_out     = i_user_pin_out;
   assign o_test_pin_oe_n    = i_port_enable ? 4'b1111 : i_user_pin_oe_n;
   assign o_test_pin_user_in = i_port_enable ? 4'b0000 : {i_tdi, i_tms, 2'b00};

   // Update stages cross by toggle: the word is taken only after the toggle has passed two
   // flip-flops, so upd_r has been steady for at least a full system cycle by then.
   logic               ut_s1_r;
   logic               ut_s2_r;
   logic               ut_s3_r;
   logic [CHAIN_W-1:0] upd_sys_r;
   logic               ext_s1_r;
   logic               ext_s2_r;
   pin_drive_s         drive_r;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ut_s1_r   <= 1'b0;
         ut_s2_r   <= 1'b0;
         ut_s3_r   <= 1'b0;
         upd_sys_r <= '0;
         ext_s1_r  <= 1'b0;
         ext_s2_r  <= 1'b0;
      end else begin
         ut_s1_r   <= upd_tgl_r;
         ut_s2_r   <= ut_s1_r;
         ut_s3_r   <= ut_s2_r;
         if (ut_s2_r != ut_s3_r) upd_sys_r <= upd_r;
         ext_s1_r  <= sel_extest && i_port_enable;
         ext_s2_r  <= ext_s1_r;
      end
   end

   pin_drive_s drive_nxt;
   always_comb begin
      drive_nxt = '0;
      for (int i = 0; i < PIN_N; i++) begin
         drive_nxt.data[i] = upd_sys_r[i*PIN_CELL_W + 1];
         drive_nxt.oe[i]   = upd_sys_r[i*PIN_CELL_W + 2];
      end
      for (int m = 0; m < MC_N; m++) begin
         drive_nxt.mc[m] = upd_sys_r[PIN_N*PIN_CELL_W + m*MC_CELL_W];
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) drive_r <= '0;
      else drive_r <= drive_nxt;
   end
   assign o_pin_drive = drive_r;
   assign o_extest    = ext_s2_r;

   // Programming words cross by toggle; the held word is stable for many TCK periods.
   logic              tg_s1_r;
   logic              tg_s2_r;
   logic              tg_s3_r;
   logic [PROG_W-1:0] pw_r;
   logic              fifo_ready;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
         pw_r    <= '0;
         o_prog_overflow <= 1'b0;
      end else begin
         tg_s1_r <= prog_tgl_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
         if (tg_s2_r != tg_s3_r) pw_r <= prog_hold_r;
         // A word that meets a full FIFO is lost; sticky flag reports it.
         if ((tg_s2_r != tg_s3_r) && !fifo_ready) o_prog_overflow <= 1'b1;
      end
   end
   logic pw_valid_r;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) pw_valid_r <= 1'b0;
      else pw_valid_r <= (tg_s2_r != tg_s3_r);
   end

   scan_word_fifo #(.WIDTH(PROG_W), .DEPTH(FIFO_DEPTH)) u_prog_fifo (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_in_valid  (pw_valid_r),
      .o_in_ready  (fifo_ready),
      .i_in_data   (pw_r),
      .o_out_valid (o_prog_valid),
      .i_out_ready (i_prog_ready),
      .o_out_data  (o_prog_data)
   );
endmodule // scan_test_port

// ### sim/scan_test_port_sva.sv
// Port-level assertions of the boundary-scan test port.
`timescale 1ns/1ns
module scan_test_port_sva
   import scan_port_pkg::*;
(
   input wire logic              i_clk_sys,
   input wire logic              i_reset,
   input wire logic              i_tck,
   input wire logic              i_port_enable,
   input wire logic              i_pullup_enable,
   input wire logic              i_tms,
   input wire logic              i_tdi,
   input wire logic              o_tdo,
   input wire logic              o_tms_pullup,
   input wire logic              o_tdi_pullup,
   input wire logic [3:0]        i_user_pin_out,
   input wire logic [3:0]        i_user_pin_oe_n,
   input wire logic [3:0]        o_test_pin_out,
   input wire logic [3:0]        o_test_pin_oe_n,
   input wire logic [3:0]        o_test_pin_user_in,
   input wire logic              o_extest,
   input wire logic              o_prog_valid,
   input wire logic              i_prog_ready,
   input wire logic [PROG_W-1:0] o_prog_data,
   input wire logic              o_prog_overflow
);
   logic tdo_rise_r;

   // TDO as seen at the last rising TCK edge; it must still hold when TCK falls.
   always_ff @(posedge i_tck or posedge i_reset) begin
      if (i_reset) begin
         tdo_rise_r <= 1'b0;
      end else begin
         tdo_rise_r <= o_tdo;
      end
   end

   a_tdo_fall_only: assert property (@(negedge i_tck) disable iff (i_reset)
      o_tdo == tdo_rise_r) else $error("TDO moved on a rising TCK edge");
   a_tms_pull_cfg: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_tms_pullup == (i_port_enable && i_pullup_enable)) else $error("TMS pull-up wrong");
   a_tdi_pull_cfg: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_tdi_pullup == (i_port_enable && i_pullup_enable)) else $error("TDI pull-up wrong");
   a_user_oe_pass: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_test_pin_oe_n == (i_port_enable ? 4'hF : i_user_pin_oe_n)) else $error("pin oe wrong");
   a_user_in_view: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_test_pin_user_in == (i_port_enable ? 4'h0 : {i_tdi, i_tms, 2'b00}))
      else $error("user input view wrong");
   a_pin_out_pass: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_test_pin_out == i_user_pin_out) else $error("pin output wrong");
   a_extest_port_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !i_port_enable [*3] |-> !o_extest) else $error("extest with port off");
   a_ovf_sticky: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_prog_overflow |=> o_prog_overflow) else $error("overflow flag cleared");
   a_prog_word_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_prog_valid && !i_prog_ready |=> o_prog_valid && $stable(o_prog_data))
      else $error("word dropped while stalled");
endmodule // scan_test_port_sva

bind scan_test_port scan_test_port_sva i_sva (
   .i_clk_sys, .i_reset, .i_tck, .i_port_enable, .i_pullup_enable, .i_tms, .i_tdi, .o_tdo,
   .o_tms_pullup, .o_tdi_pullup, .i_user_pin_out, .i_user_pin_oe_n, .o_test_pin_out,
   .o_test_pin_oe_n, .o_test_pin_user_in, .o_extest, .o_prog_valid, .i_prog_ready,
   .o_prog_data, .o_prog_overflow
);

// ### sim/jtag_tester.sv
// Behavioural JTAG tester that drives TCK, TMS and TDI and reads TDO.
`timescale 1ns/1ns
module jtag_tester (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo
);
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // One TCK period; TCK rests low between frames and TDO is read at the rising edge.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #80 o_tck = 1'b1;
      tdo = i_tdo;
      #80 o_tck = 1'b0;
   endtask

   // Idle to Shift-xR, n bits LSB first, then Update and back to Idle.
   task automatic scan(input logic ir, input logic [31:0] din, input int n,
                       output logic [31:0] dout);
      logic t;
      dout = 32'h0;
      step(1'b1, 1'b0, t);
      if (ir) step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
      step(1'b0, 1'b0, t);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, din[k], t);
         dout[k] = t;
      end
      step(1'b1, ~din[n-1], t);
      step(1'b0, ~din[n-1], t);
      // A released TDI shows the inverse of its last bit, so a stale value cannot pass.
      o_tdi = ~din[n-1];
   endtask
endmodule // jtag_tester

// ### sim/scan_test_port_tb_top.sv
// Self-checking testbench of the boundary-scan test port.
`timescale 1ns/1ns
module scan_test_port_tb_top
   import scan_port_pkg::*;
;
   logic              i_clk_sys, i_reset, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n;
   logic              i_port_enable, i_pullup_enable, o_tms_pullup, o_tdi_pullup;
   logic              i_prog_ready, o_prog_valid, o_prog_overflow, o_extest;
   logic [3:0]        i_user_pin_out, i_user_pin_oe_n;
   logic [3:0]        o_test_pin_out, o_test_pin_oe_n, o_test_pin_user_in;
   logic [PIN_N-1:0]  i_pin_in, i_core_out, i_core_oe;
   logic [MC_N-1:0]   i_mc_state;
   logic [PROG_W-1:0] o_prog_data;
   pin_drive_s        o_pin_drive;
   logic [31:0]       d;
   int                failures, total_checks, cycles;

   scan_test_port i_dut (
      .i_clk_sys, .i_reset, .i_tck, .i_port_enable, .i_pullup_enable, .i_tms, .i_tdi, .o_tdo,
      .o_tdo_oe_n, .o_tms_pullup, .o_tdi_pullup, .i_user_pin_out, .i_user_pin_oe_n,
      .o_test_pin_out, .o_test_pin_oe_n, .o_test_pin_user_in, .i_pin_in, .i_core_out,
      .i_core_oe, .i_mc_state, .o_pin_drive, .o_extest, .o_prog_valid, .i_prog_ready,
      .o_prog_data, .o_prog_overflow
   );
   jtag_tester jt (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo));

   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end

   // The full run needs about 2000 cycles; the ceiling leaves room for slow crossings.
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (failures == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic sys_wait(input int n);
      repeat (n) @(posedge i_clk_sys);
      #2;
   endtask

   task automatic t_idcode();
      jt.step(1'b0, 1'b0, d[0]);
      jt.scan(1'b0, 32'h0, 32, d);
      check(d, ID_VALUE);
      sys_wait(1);
      check(32'(o_tdo_oe_n), 32'h0000_0001);
      jt.step(1'b1, 1'b0, d[0]);
      jt.step(1'b0, 1'b0, d[0]);
      jt.step(1'b0, 1'b0, d[0]);
      sys_wait(1);
      check(32'(o_tdo_oe_n), 32'h0000_0000);
      jt.step(1'b1, 1'b0, d[0]);
      jt.step(1'b1, 1'b0, d[0]);
      jt.step(1'b0, 1'b0, d[0]);
   endtask

   task automatic t_bypass();
      logic [3:0] code [2] = '{IR_BYPASS, 4'h5};
      foreach (code[k]) begin
         jt.scan(1'b1, 32'(code[k]), 4, d);
         check(32'(d[3:0]), 32'(IR_CAPTURE));
         jt.scan(1'b0, 32'h0000_00A5, 8, d);
         check(32'(d[7:0]), 32'h0000_004A);
      end
   endtask

   task automatic t_sample();
      logic [31:0] p;
      logic [31:0] e;
      pin_drive_s  q;
      p = 32'h5A3C_96E1;
      for (int i = 0; i < PIN_N; i++) begin
         e[3*i +: 3] = {i_core_oe[i], i_core_out[i], i_pin_in[i]};
         q.data[i] = p[3*i+1];
         q.oe[i] = p[3*i+2];
      end
      for (int m = 0; m < MC_N; m++) begin
         e[PIN_N*PIN_CELL_W+2*m +: 2] = {1'b0, i_mc_state[m]};
         q.mc[m] = p[PIN_N*PIN_CELL_W+2*m];
      end
      jt.scan(1'b1, 32'(IR_SAMPLE), 4, d);
      jt.scan(1'b0, p, 32, d);
      check(d, e);
      sys_wait(10);
      check(32'(o_pin_drive), 32'(q));
      jt.scan(1'b1, 32'(IR_EXTEST), 4, d);
      sys_wait(10);
      check(32'({o_extest, o_pin_drive}), 32'({1'b1, q}));
      jt.scan(1'b1, 32'(IR_SAMPLE), 4, d);
      sys_wait(10);
      check(32'(o_extest), 32'h0);
   endtask

   // The consumer stalls until the buffer has refused a word, then drains it.
   task automatic t_prog();
      int n;
      jt.scan(1'b1, 32'(IR_PROGRAM), 4, d);
      for (int w = 0; w <= FIFO_DEPTH; w++) begin
         jt.scan(1'b0, 32'(16'hC300 + w), PROG_W, d);
         sys_wait(10);
         check(32'(o_prog_overflow), 32'(w == FIFO_DEPTH));
      end
      for (int w = 0; w < FIFO_DEPTH; w++) begin
         n = 0;
         while (o_prog_valid !== 1'b1 && n < 50) begin
            sys_wait(1);
            n++;
         end
         check(32'(o_prog_data), 32'(16'hC300 + w));
         i_prog_ready = 1'b1;
         sys_wait(1);
         i_prog_ready = 1'b0;
         sys_wait(1);
      end
      sys_wait(5);
      check(32'(o_prog_valid), 32'h0);
   endtask

   // EXTEST is loaded first so that turning the port off must also drop it.
   task automatic t_pins();
      jt.scan(1'b1, 32'(IR_EXTEST), 4, d);
      sys_wait(10);
      check(32'(o_extest), 32'h0000_0001);
      i_port_enable = 1'b0;
      jt.o_tms = 1'b0;
      jt.o_tdi = 1'b1;
      sys_wait(2);
      check(32'({o_extest, o_test_pin_oe_n, o_test_pin_out}), 32'h0000_006A);
      check(32'({o_test_pin_user_in, o_tms_pullup, o_tdi_pullup}), 32'h0000_0020);
      i_port_enable = 1'b1;
      i_pullup_enable = 1'b1;
      sys_wait(2);
      check(32'({o_tms_pullup, o_tdi_pullup, o_test_pin_oe_n}), 32'h0000_003F);
   endtask

   initial begin
      i_reset = 1'b1;
      i_port_enable = 1'b1;
      i_pullup_enable = 1'b0;
      i_prog_ready = 1'b0;
      i_user_pin_out = 4'hA;
      i_user_pin_oe_n = 4'h6;
      i_pin_in = 8'h3C;
      i_core_out = 8'h96;
      i_core_oe = 8'hF0;
      i_mc_state = 4'h9;
      jt.step(1'b1, 1'b0, d[0]);
      sys_wait(16);
      i_reset = 1'b0;
      t_idcode();
      t_bypass();
      t_sample();
      t_prog();
      t_pins();
      finish_test();
   end
endmodule // scan_test_port_tb_top
